// ---- hw/tcss_pkg.sv ----
// Purpose: shared constants for the timer compare / slave sync block
// Assumes: one clock at 250 MHz, APB slave with 32-bit data
// Notes:   offsets are byte addresses of aligned words
package tcss_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] TCSS_CTRL_OFS   = 8'h00; // timer_control_one
    localparam logic [7:0] TCSS_SMC_OFS    = 8'h04; // slave_mode_control
    localparam logic [7:0] TCSS_PERIOD_OFS = 8'h08; // period_value
    localparam logic [7:0] TCSS_CMP_OFS    = 8'h0C; // compare_value
    localparam logic [7:0] TCSS_REP_OFS    = 8'h10; // repetition_count
    localparam logic [7:0] TCSS_CNT_OFS    = 8'h14; // counter_value, read only
    localparam logic [7:0] TCSS_STAT_OFS   = 8'h18; // sticky status, read clears
    localparam logic [7:0] TCSS_MASK_OFS   = 8'h1C; // interrupt mask
    // ****************************************************************
    // control field positions
    // ****************************************************************
    localparam int CTRL_EN_BIT    = 0; // counter enable
    localparam int CTRL_OPM_BIT   = 1; // one_pulse_select
    localparam int CTRL_CMS_BIT   = 2; // center-aligned counting
    localparam int CTRL_TOG_BIT   = 3; // toggle output mode
    localparam int CTRL_CLREN_BIT = 4; // compare clear enable
    localparam int CTRL_AOE_BIT   = 5; // auto_output_enable
    localparam int SMC_MSM_BIT    = 4; // master_slave_sync
    // ****************************************************************
    // status bits
    // ****************************************************************
    localparam int ST_CMP_BIT  = 0; // compare event
    localparam int ST_UPD_BIT  = 1; // update (wrap/valley)
    localparam int ST_TRG_BIT  = 2; // trigger taken
    localparam int ST_BRK_BIT  = 3; // break seen
    localparam int ST_W        = 4;
    // ****************************************************************
    // slave modes and reset values
    // ****************************************************************
    typedef enum logic [3:0] {
        TCSS_SM_OFF      = 4'h0,
        TCSS_SM_RESET    = 4'h4,
        TCSS_SM_GATED    = 4'h5,
        TCSS_SM_TRIGGER  = 4'h6,
        TCSS_SM_RST_TRIG = 4'h8,
        TCSS_SM_GATE_RST = 4'h9
    } tcss_smode_e;
    localparam logic [15:0] TCSS_PERIOD_RST = 16'hFFFF;
    localparam logic [15:0] TCSS_ZERO16     = 16'h0000;
endpackage : tcss_pkg

// ---- hw/tcss_sync_delay.sv ----
// Purpose: optional one-cycle delay of the trigger pulse
// Assumes: trigger is a one-cycle pulse in the clk domain
// Notes:   bypass when sync is cleared gives the lower latency
`timescale 1ns/1ps
module tcss_sync_delay
    import tcss_pkg::*;
(
    input  wire logic clk,      // timer clock
    input  wire logic rst_b,    // sync reset, active low
    input  wire logic sync_en,  // master_slave_sync
    input  wire logic trig_in,  // raw trigger pulse
    output logic      trig_out  // trigger seen by the counter
);
    // ****************************************************************
    // delay stage
    // ****************************************************************
    logic trig_q;      // delayed trigger
    logic next_trig_q; // its next value

    // capture the pulse one cycle late
    always_comb begin
        next_trig_q = trig_in;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= next_trig_q;
        end
    end

    // sync set adds the delay, cleared passes straight through
    assign trig_out = sync_en ? trig_q : trig_in;

    AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (!rst_b)
        sync_en && $past(sync_en) ##0 $past(trig_in) |-> trig_out)
        else $error("delayed trigger not passed");
    AST_SYNC_BYPASS: assert property (@(posedge clk) disable iff (!rst_b)
        !sync_en |-> (trig_out == trig_in))
        else $error("bypass trigger mismatch");
endmodule : tcss_sync_delay

// ---- hw/tcss_apb_regs.sv ----
// Purpose: APB register file with sticky status and mask
// Assumes: zero wait states, read of status clears it
// Notes:   set wins over a clear in the same cycle
`timescale 1ns/1ps
module tcss_apb_regs
    import tcss_pkg::*;
(
    input  wire logic        clk,        // timer clock
    input  wire logic        rst_b,      // sync reset, active low
    input  wire logic        psel,       // apb select
    input  wire logic        penable,    // apb access phase
    input  wire logic        pwrite,     // apb direction
    input  wire logic [7:0]  paddr,      // apb byte address
    input  wire logic [31:0] pwdata,     // apb write data
    output logic [31:0]      prdata,     // apb read data
    output logic             pready,     // apb ready
    output logic             pslverr,    // apb error
    input  wire logic [15:0] cnt_val,    // live counter
    input  wire logic [ST_W-1:0] ev_set, // event pulses
    output logic [7:0]       ctrl,       // timer_control_one
    output logic [7:0]       smc,        // slave_mode_control
    output logic [15:0]      period,     // period_value
    output logic [15:0]      cmp,        // compare_value
    output logic [7:0]       rep,        // repetition_count
    output logic             irq         // level interrupt
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic [ST_W-1:0] stat;     // sticky events
    logic [ST_W-1:0] mask;     // interrupt mask
    logic [ST_W-1:0] next_stat;
    logic [ST_W-1:0] next_mask;
    logic [7:0]      next_ctrl, next_smc, next_rep;
    logic [15:0]     next_period, next_cmp;
    logic            wr, rd, hit;

    assign pready = 1'b1;
    assign wr     = psel && penable && pwrite;
    assign rd     = psel && penable && !pwrite;

    // address decode
    always_comb begin
        hit = 1'b1;
        unique case (paddr)
            TCSS_CTRL_OFS, TCSS_SMC_OFS, TCSS_PERIOD_OFS, TCSS_CMP_OFS,
            TCSS_REP_OFS, TCSS_CNT_OFS, TCSS_STAT_OFS, TCSS_MASK_OFS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !hit;

    // next register values
    always_comb begin
        next_ctrl   = ctrl;
        next_smc    = smc;
        next_period = period;
        next_cmp    = cmp;
        next_rep    = rep;
        next_mask   = mask;
        next_stat   = stat;
        if (rd && paddr == TCSS_STAT_OFS) begin
            next_stat = '0; // read clears
        end
        next_stat = next_stat | ev_set;
        if (wr) begin
            unique case (paddr)
                TCSS_CTRL_OFS:   next_ctrl   = pwdata[7:0];
                TCSS_SMC_OFS:    next_smc    = pwdata[7:0];
                TCSS_PERIOD_OFS: next_period = pwdata[15:0];
                TCSS_CMP_OFS:    next_cmp    = pwdata[15:0];
                TCSS_REP_OFS:    next_rep    = pwdata[7:0];
                TCSS_MASK_OFS:   next_mask   = pwdata[ST_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl   <= 8'h00;
            smc    <= 8'h00;
            period <= TCSS_PERIOD_RST;
            cmp    <= TCSS_ZERO16;
            rep    <= 8'h00;
            mask   <= '0;
            stat   <= '0;
        end else begin
            ctrl   <= next_ctrl;
            smc    <= next_smc;
            period <= next_period;
            cmp    <= next_cmp;
            rep    <= next_rep;
            mask   <= next_mask;
            stat   <= next_stat;
        end
    end

    // read mux
    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            TCSS_CTRL_OFS:   prdata = {24'h00_0000, ctrl};
            TCSS_SMC_OFS:    prdata = {24'h00_0000, smc};
            TCSS_PERIOD_OFS: prdata = {16'h0000, period};
            TCSS_CMP_OFS:    prdata = {16'h0000, cmp};
            TCSS_REP_OFS:    prdata = {24'h00_0000, rep};
            TCSS_CNT_OFS:    prdata = {16'h0000, cnt_val};
            TCSS_STAT_OFS:   prdata = {28'h000_0000, stat};
            TCSS_MASK_OFS:   prdata = {28'h000_0000, mask};
            default:         prdata = 32'h0000_0000;
        endcase
    end

    assign irq = |(stat & mask);

    AST_STAT_SET_WINS: assert property (@(posedge clk) disable iff (!rst_b)
        ev_set[ST_CMP_BIT] |=> stat[ST_CMP_BIT])
        else $error("compare flag lost");
endmodule : tcss_apb_regs

// ---- hw/tcss_timer.sv ----
// Purpose: timer counter with compare, toggle, slave modes, clear, break
// Assumes: all inputs synchronous to clk
// Notes:   compare is evaluated each cycle against the live compare value
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module tcss_timer
    import tcss_pkg::*;
(
    input  wire logic        clk,         // 250 MHz timer clock
    input  wire logic        rst_b,       // sync reset, active low
    input  wire logic        psel,        // apb select
    input  wire logic        penable,     // apb enable
    input  wire logic        pwrite,      // apb direction
    input  wire logic [7:0]  paddr,       // apb address
    input  wire logic [31:0] pwdata,      // apb write data
    output logic [31:0]      prdata,      // apb read data
    output logic             pready,      // apb ready
    output logic             pslverr,     // apb error
    input  wire logic        trig_in,     // external trigger pulse
    input  wire logic        ext_reset,   // external counter reset level/pulse
    input  wire logic        gate_in,     // gating level
    input  wire logic        ocref_clr,   // compare clear input
    input  wire logic        break_input, // break, active high
    output logic             trig_out,    // trigger to slave timers
    output logic             oc_out,      // compare output
    output logic             out_en,      // main output enable
    output logic             irq          // interrupt
);
    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0]  ctrl;        // timer_control_one
    logic [7:0]  smc;         // slave_mode_control
    logic [15:0] period;      // period_value
    logic [15:0] cmp;         // compare_value
    logic [7:0]  rep;         // repetition_count
    logic [ST_W-1:0] ev_set;  // event pulses
    logic        trig_eff;    // trigger after sync stage
    tcss_smode_e smode;       // decoded slave mode
    logic [15:0] counter_value; // live count, read back over the bus

    tcss_apb_regs u_regs (
        .clk     (clk),
        .rst_b   (rst_b),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .cnt_val (counter_value),
        .ev_set  (ev_set),
        .ctrl    (ctrl),
        .smc     (smc),
        .period  (period),
        .cmp     (cmp),
        .rep     (rep),
        .irq     (irq)
    );

    tcss_sync_delay u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .sync_en  (smc[SMC_MSM_BIT]),
        .trig_in  (trig_in),
        .trig_out (trig_eff)
    );

    assign smode = tcss_smode_e'(smc[3:0]);
    // master passes the raw trigger on at once so slaves land aligned
    assign trig_out = trig_in;

    // ****************************************************************
    // counter state
    // ****************************************************************
    logic        dir_down;         // center-aligned direction
    logic        running;          // counter enable state
    logic [7:0]  rep_left;         // remaining repetitions
    logic [15:0] next_counter_value;
    logic        next_dir_down, next_running;
    logic [7:0]  next_rep_left;
    logic        restart, start, gated_ok, upd_ev, at_end;

    // slave controller decode
    always_comb begin
        restart  = 1'b0;
        start    = 1'b0;
        gated_ok = 1'b1;
        unique case (smode)
            TCSS_SM_RESET:    restart = trig_eff || ext_reset;
            TCSS_SM_GATED:    gated_ok = gate_in;
            TCSS_SM_TRIGGER:  start = trig_eff;
            TCSS_SM_RST_TRIG: begin
                restart = trig_eff || ext_reset;
                start   = trig_eff;
            end
            TCSS_SM_GATE_RST: begin
                restart  = ext_reset;
                gated_ok = gate_in;
            end
            default: ;
        endcase
    end

    assign at_end = ctrl[CTRL_CMS_BIT] ? (dir_down && counter_value == TCSS_ZERO16)
                                       : (counter_value == period);

    // counter next state
    always_comb begin
        next_counter_value = counter_value;
        next_dir_down      = dir_down;
        // enable holds a free run, a one-pulse run ends by itself
        next_running       = start || ctrl[CTRL_EN_BIT] || (running && ctrl[CTRL_OPM_BIT]);
        next_rep_left      = rep_left;
        upd_ev             = 1'b0;
        if (restart) begin
            // a trigger at the period value still restarts, but no update event fires
            next_counter_value = TCSS_ZERO16;
            next_dir_down      = 1'b0;
            next_rep_left      = rep;
        end else if (running && gated_ok) begin
            if (!ctrl[CTRL_CMS_BIT]) begin
                // edge aligned wrap
                next_counter_value = (counter_value == period) ? TCSS_ZERO16
                                   : counter_value + 16'h0001;
            end else if (!dir_down) begin
                // center up leg, turn at period
                if (counter_value >= period) begin
                    next_dir_down      = 1'b1;
                    next_counter_value = counter_value - 16'h0001;
                end else begin
                    next_counter_value = counter_value + 16'h0001;
                end
            end else begin
                // center down leg, turn at zero
                if (counter_value == TCSS_ZERO16) begin
                    next_dir_down      = 1'b0;
                    next_counter_value = 16'h0001;
                end else begin
                    next_counter_value = counter_value - 16'h0001;
                end
            end
            if (at_end) begin
                upd_ev        = 1'b1;
                next_rep_left = (rep_left == 8'h00) ? rep : rep_left - 8'h01;
                // one-pulse stops at the end of the run
                if (ctrl[CTRL_OPM_BIT] && rep_left == 8'h00) begin
                    next_running       = start;
                    next_counter_value = TCSS_ZERO16;
                    next_dir_down      = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            counter_value <= TCSS_ZERO16;
            dir_down      <= 1'b0;
            running       <= 1'b0;
            rep_left      <= 8'h00;
        end else begin
            counter_value <= next_counter_value;
            dir_down      <= next_dir_down;
            running       <= next_running;
            rep_left      <= next_rep_left;
        end
    end

    // ****************************************************************
    // compare and output
    // ****************************************************************
    logic cmp_ev;        // match this cycle, no edge memory used
    logic oc_ref;        // reference output level
    logic clr_latch;     // output held cleared
    logic next_oc_ref, next_clr_latch, next_out_en;

    // every running cycle with a match is an event, even back to back
    assign cmp_ev = running && (counter_value == cmp);

    always_comb begin
        next_oc_ref    = oc_ref;
        next_clr_latch = clr_latch;
        next_out_en    = out_en;
        if (ctrl[CTRL_TOG_BIT]) begin
            if (cmp_ev) next_oc_ref = !oc_ref;
        end else begin
            // pwm: active below compare
            next_oc_ref = (next_counter_value < cmp);
        end
        if (ctrl[CTRL_CLREN_BIT] && ocref_clr) begin
            next_clr_latch = 1'b1;
        end else if (restart || upd_ev) begin
            next_clr_latch = 1'b0;
        end
        if (break_input) begin
            next_out_en = 1'b0;
        end else if (!out_en && ctrl[CTRL_AOE_BIT] && upd_ev) begin
            next_out_en = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            oc_ref    <= 1'b0;
            clr_latch <= 1'b0;
            out_en    <= 1'b1;
        end else begin
            oc_ref    <= next_oc_ref;
            clr_latch <= next_clr_latch;
            out_en    <= next_out_en;
        end
    end

    assign oc_out = oc_ref && !clr_latch && out_en;
    assign ev_set = {break_input, start, upd_ev, cmp_ev};

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_CMP_EVERY: assert property (@(posedge clk) disable iff (!rst_b)
        running && counter_value == cmp |=> u_regs.stat[ST_CMP_BIT])
        else $error("compare match without event");
    AST_EDGE_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
        running && !restart && gated_ok && !ctrl[CTRL_CMS_BIT]
        && !ctrl[CTRL_OPM_BIT] && counter_value == period |=> counter_value == 16'h0000)
        else $error("edge counter did not wrap");
    AST_TOGGLE: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl[CTRL_TOG_BIT] && cmp_ev |=> oc_ref != $past(oc_ref))
        else $error("toggle missed");
    AST_BACK_TO_BACK: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl[CTRL_TOG_BIT] && cmp_ev ##1 (ctrl[CTRL_TOG_BIT] && cmp_ev)
        |=> oc_ref == $past(oc_ref, 2))
        else $error("two events did not give a pulse");
    AST_CLR_RELEASE: assert property (@(posedge clk) disable iff (!rst_b)
        clr_latch && restart && !(ctrl[CTRL_CLREN_BIT] && ocref_clr) |=> !clr_latch)
        else $error("clear held past timer reset");
    AST_BREAK: assert property (@(posedge clk) disable iff (!rst_b)
        break_input |=> !out_en && !oc_out)
        else $error("break did not clear output");
    AST_RESTART: assert property (@(posedge clk) disable iff (!rst_b)
        restart |=> counter_value == 16'h0000)
        else $error("restart not honoured");
    AST_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
        cmp_ev ##1 u_regs.mask[ST_CMP_BIT] |-> irq)
        else $error("enabled compare gave no interrupt");

    COV_TOGGLE_PULSE: cover property (@(posedge clk) disable iff (!rst_b)
        cmp_ev ##1 cmp_ev);
    COV_CENTER_TURN: cover property (@(posedge clk) disable iff (!rst_b)
        !dir_down ##1 dir_down);
    COV_TRIG_AT_PERIOD: cover property (@(posedge clk) disable iff (!rst_b)
        trig_eff && counter_value == period);
    COV_AOE: cover property (@(posedge clk) disable iff (!rst_b)
        !out_en ##1 out_en);
endmodule : tcss_timer

// ---- tb/tcss_trig_src.sv ----
// Purpose: trigger source model standing in for a cascaded master timer
// Assumes: one clock, the pulse is launched just after a rising edge
// Notes:   a slow answer waits three cycles before the pulse
`timescale 1ns/1ps
module tcss_trig_src (
    input  wire logic clk,  // shared timer clock
    input  wire logic fire, // request one trigger
    input  wire logic slow, // late answer
    output logic      trig  // one-cycle trigger pulse
);
    // ****************************************************************
    // pulse one cycle wide, prompt or late, low between pulses
    // ****************************************************************
    initial trig = 1'b0;
    always @(posedge clk) begin
        if (fire) begin
            if (slow) repeat (3) @(posedge clk);
            trig <= 1'b1;
            @(posedge clk);
            trig <= 1'b0;
        end
    end
endmodule : tcss_trig_src

// ---- tb/timer_compare_slave_sync_bench.sv ----
// Purpose: self-checking bench for the timer compare / slave sync block
// Assumes: zero-wait APB, reads scored from a queue of expected notes
// Notes:   status bits outside the mask of a note are not compared
`timescale 1ns/1ps
module timer_compare_slave_sync_bench;
    import tcss_pkg::*;
    logic        clk, rst_b, psel, penable, pwrite, pslverr, pready;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic        ext_reset, gate_in, ocref_clr, break_input, fire, slow;
    logic        trig_in, trig_out, oc_out, out_en, irq, oc_prev;
    logic [65:0] exp_q[$];  // {mask, expected} of each read
    int          miscompares, checks, cyc, n;
    tcss_timer dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .ext_reset(ext_reset),
        .gate_in(gate_in), .ocref_clr(ocref_clr), .break_input(break_input),
        .trig_out(trig_out), .oc_out(oc_out), .out_en(out_en), .irq(irq));
    tcss_trig_src src (.clk(clk), .fire(fire), .slow(slow), .trig(trig_in));
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return (x >> 1) ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
    endfunction : lfsr
    task automatic cmp_rd(input logic [32:0] got, input logic [65:0] note);
        checks++;
        if (((got & note[65:33]) ^ note[32:0]) !== 33'h0_0000_0000) begin
            miscompares++;
            $display("unexpected read at %0t: %h", $time, got);
        end
    endtask : cmp_rd
    task automatic cmp_lvl(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected level at %0t: %b", $time, got);
        end
    endtask : cmp_lvl
    // one APB transfer, a read leaves a note for the watcher
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] m, input logic [32:0] e);
        @(posedge clk);
        if (!w) exp_q.push_back({m, e});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic final_report;
        if (miscompares == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    // ****************************************************************
    // clock, watchers and timeout
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (psel && penable && pready && !pwrite) cmp_rd({pslverr, prdata}, exp_q.pop_front());
        if (trig_in === 1'b1) cmp_lvl(trig_out, 1'b1);
        if (cyc == 4000) begin
            miscompares++;
            final_report();
        end
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_reset, gate_in, ocref_clr, break_input, fire, slow} = '0;
        rnd = 32'h7a27_95fc;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, TCSS_CTRL_OFS, 0, '1, 33'h0_0000_0000);
        apb(0, TCSS_PERIOD_OFS, 0, '1, 33'h0_0000_FFFF);
        apb(0, TCSS_STAT_OFS, 0, '1, 33'h0_0000_0000);
        apb(1, 8'h20, 32'h0000_00FF, '1, '0);
        apb(0, 8'h20, 0, '1, 33'h1_0000_0000);
        // center mode, random compare inside the period
        rnd = lfsr(rnd);
        apb(1, TCSS_PERIOD_OFS, 32'h0000_0007, '0, '0);
        apb(1, TCSS_CMP_OFS, {29'h0, rnd[2:0] | 3'h1}, '0, '0);
        apb(1, TCSS_MASK_OFS, 32'h0000_0001, '0, '0);
        apb(1, TCSS_CTRL_OFS, 32'h0000_0005, '0, '0);
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        cmp_lvl(irq, 1'b1);
        apb(1, TCSS_CTRL_OFS, 0, '0, '0);
        apb(0, TCSS_STAT_OFS, 0, 33'h0_0000_0001, 33'h0_0000_0001);
        apb(0, TCSS_STAT_OFS, 0, 33'h0_0000_0001, 33'h0_0000_0000);
        cmp_lvl(irq, 1'b0);
        // toggle mode: 80 cycles hold ten periods of eight
        apb(1, TCSS_CMP_OFS, 32'h0000_0003, '0, '0);
        apb(1, TCSS_CTRL_OFS, 32'h0000_0009, '0, '0);
        n = 0;
        repeat (2) @(posedge clk);
        oc_prev = oc_out;
        repeat (80) begin
            @(posedge clk);
            if (oc_out !== oc_prev) n++;
            oc_prev = oc_out;
        end
        cmp_lvl(n == 10, 1'b1);
        // break drops the enable, auto enable brings it back
        apb(1, TCSS_CTRL_OFS, 32'h0000_0021, '0, '0);
        break_input <= 1'b1;
        repeat (2) @(posedge clk);
        cmp_lvl(out_en, 1'b0);
        break_input <= 1'b0;
        repeat (20) @(posedge clk);
        cmp_lvl(out_en, 1'b1);
        // triggers in reset-plus-trigger mode, sync off and on
        for (int i = 0; i < 4; i++) begin
            apb(1, TCSS_SMC_OFS, {27'h0, i[0], 4'h8}, '0, '0);
            apb(0, TCSS_STAT_OFS, 0, '0, '0);
            slow <= i[1];
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            repeat (8) @(posedge clk);
            apb(0, TCSS_STAT_OFS, 0, 33'h0_0000_0004, 33'h0_0000_0004);
            // restart edge: one cycle later with sync set
            apb(0, TCSS_CNT_OFS, 0, 33'h0_0000_FFFF, 33'((i[1] ? 9 : 12) - i[0]) & 33'h7);
        end
        // one-pulse run started by a trigger stops by itself at zero
        apb(1, TCSS_CTRL_OFS, 32'h0000_0002, '0, '0);
        repeat (10) @(posedge clk);
        apb(0, TCSS_STAT_OFS, 0, '0, '0);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (30) @(posedge clk);
        apb(0, TCSS_STAT_OFS, 0, 33'h0_0000_0002, 33'h0_0000_0002);
        apb(0, TCSS_CNT_OFS, 0, 33'h1_0000_FFFF, 33'h0_0000_0000);
        // compare clear, then an external reset releases it at once
        apb(1, TCSS_SMC_OFS, 32'h0000_0004, '0, '0);
        apb(1, TCSS_CTRL_OFS, 32'h0000_0011, '0, '0);
        ocref_clr <= 1'b1;
        @(posedge clk);
        ocref_clr <= 1'b0;
        ext_reset <= 1'b1;
        @(posedge clk);
        cmp_lvl(oc_out, 1'b0);
        ext_reset <= 1'b0;
        @(posedge clk);
        cmp_lvl(oc_out, 1'b1);
        final_report();
    end
endmodule : timer_compare_slave_sync_bench
